// ===== verilog/fpexc_consts.svh
/*
 fpexc_consts.svh: field positions, trap-type codes and reset values of
 the floating-point status register and of the exception logic.
 assumes: included by bare name wherever the fields are decoded.
*/
`ifndef FPEXC_CONSTS_SVH
`define FPEXC_CONSTS_SVH

// exception group: invalid, overflow, underflow, division by zero, inexact
`define FPEXC_NV 4
`define FPEXC_OF 3
`define FPEXC_UF 2
`define FPEXC_DZ 1
`define FPEXC_NX 0
`define FPEXC_GRP_W 5
`define FPEXC_GRP_ZERO 5'h00

// status register fields
`define FPEXC_CEXC_HI 4
`define FPEXC_CEXC_LO 0
`define FPEXC_AEXC_HI 9
`define FPEXC_AEXC_LO 5
`define FPEXC_TEM_HI 27
`define FPEXC_TEM_LO 23
`define FPEXC_NS_BIT 22
`define FPEXC_FTT_HI 16
`define FPEXC_FTT_LO 14
`define FPEXC_SR_W 64
`define FPEXC_SR_RESET 64'h0000_0000_0000_0000
`define FPEXC_SR_LOW_MASK 64'h0000_0000_ffff_ffff
// writable bits: fcc fields, rounding, tem, ns, aexc, cexc
`define FPEXC_SR_WR_MASK 64'h0000_003f_cfc0_0fff

// trap-type codes
`define FPEXC_FTT_W 3
`define FPEXC_FTT_NONE 3'h0
`define FPEXC_FTT_STD 3'h1
`define FPEXC_FTT_INCOMPLETE 3'h2
`define FPEXC_FTT_UNSUPPORTED 3'h3

// biased result exponent window for incomplete multiply and divide
`define FPEXC_ER_W 13
`define FPEXC_ER_MIN_SGL 13'sh1fe7
`define FPEXC_ER_MIN_DBL 13'sh1fca
`define FPEXC_ER_MAX 13'sh0001

`endif

// ===== verilog/fpexc_pkg.sv
/*
 fpexc_pkg.sv: types shared by the exception unit and its incomplete-op
 checker.
 assumes: fpexc_consts.svh supplies the numeric constants.
*/
`include "fpexc_consts.svh"

package fpexc_pkg;
   // operation classes, one-hot
   typedef enum logic [6:0] {
      FPEXC_OP_ADDSUB = 7'h01,
      FPEXC_OP_MUL = 7'h02,
      FPEXC_OP_DIV = 7'h04,
      FPEXC_OP_SQRT = 7'h08,
      FPEXC_OP_CVT = 7'h10,
      FPEXC_OP_SMULD = 7'h20,
      FPEXC_OP_OTHER = 7'h40
   } fpexc_op_t;

   typedef logic [`FPEXC_GRP_W-1:0] fpexc_grp_t;
   typedef logic [`FPEXC_FTT_W-1:0] fpexc_ftt_t;
endpackage : fpexc_pkg

// ===== verilog/fpexc_if.sv
/*
 fpexc_if.sv: carries an operation's class and operand facts from the
 exception unit to the incomplete-op checker and the verdict back.
 assumes: both ends share one clock; the signals are combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpexc_consts.svh"

interface fpexc_if;
   fpexc_pkg::fpexc_op_t opClass;
   logic isDouble;
   logic anySubnormal;
   logic productZero;
   logic signed [`FPEXC_ER_W-1:0] resultExp;
   logic flushEffective;
   logic incomplete;

   modport unit (output opClass, isDouble, anySubnormal, productZero,
      resultExp, flushEffective, input incomplete);
   modport check (input opClass, isDouble, anySubnormal, productZero,
      resultExp, flushEffective, output incomplete);
endinterface : fpexc_if

`default_nettype wire

// ===== verilog/fpexc_incomplete.sv
/*
 fpexc_incomplete.sv: decides whether an operation must be handed to
 software as incomplete (subnormal operands, risky result exponents).
 assumes: operand facts are stable in the cycle the unit samples them.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpexc_consts.svh"

module fpexc_incomplete (
   // link to the exception unit
   fpexc_if.check chk
);
   wire logic erAboveMin;
   wire logic erBelowMax;
   wire logic erInWindow;
   wire logic noFlush;
   wire logic sbnOps;
   wire logic mulCase;
   wire logic divCase;

   // flushing off (interval mode already folded in) enables these traps
   assign noFlush = !chk.flushEffective;
   assign erAboveMin = chk.isDouble ?
      (chk.resultExp > `FPEXC_ER_MIN_DBL) :
      (chk.resultExp > `FPEXC_ER_MIN_SGL);
   assign erBelowMax = chk.resultExp <= `FPEXC_ER_MAX;
   assign erInWindow = erAboveMin && erBelowMax;

   // subnormal operands to these classes go to software whenever flushing is off
   assign sbnOps = chk.anySubnormal &&
      (chk.opClass == fpexc_pkg::FPEXC_OP_ADDSUB ||
       chk.opClass == fpexc_pkg::FPEXC_OP_DIV ||
       chk.opClass == fpexc_pkg::FPEXC_OP_SQRT ||
       chk.opClass == fpexc_pkg::FPEXC_OP_CVT ||
       chk.opClass == fpexc_pkg::FPEXC_OP_SMULD);
   // a zero product with a subnormal operand is exact, hardware keeps it
   assign mulCase = chk.opClass == fpexc_pkg::FPEXC_OP_MUL &&
      !chk.productZero && (chk.anySubnormal || erInWindow);
   assign divCase = chk.opClass == fpexc_pkg::FPEXC_OP_DIV &&
      erInWindow;

   assign chk.incomplete = noFlush && (sbnOps || mulCase || divCase);
endmodule : fpexc_incomplete

`default_nettype wire

// ===== verilog/fpexc_unit.sv
/*
 fpexc_unit.sv: floating-point exception detection, current and accrued
 flags, trap-type field and trap decision, with the status register that
 the status load and store instructions reach.
 assumes: the datapath presents one completing operation per opDone pulse
 with its raw facts, all on mclk; loads and stores arrive as pulses and
 never in the same cycle as opDone.
*/
// Function
// - on any trap accrued flags stay unchanged
// - misc trap types never touch current flags
// - trapping operation blocks register and fcc writes
// - unimplemented operation gives unsupported trap type
// - every quad variant is reported unsupported
// - mask bits 27..23 gate the standard trap
// - mask AND current traps, else OR into accrued
// - both status loads write the accrued field
// - bits 4..0 hold last operation's exceptions
// - taken standard trap sets exactly one current bit
// - unmasked overflow sets overflow and inexact only
// - masked overflow or inexact traps with single bit
// - unmasked underflow sets underflow and inexact only
// - masked underflow or inexact traps with single bit
// - non-standard traps leave current flags untouched
// - underflow before rounding, never for exact zero
// - nonzero finite over zero flags division by zero
// - improper operands such as 0/0 flag invalid
// - overflow when unbounded rounded result exceeds max
// - inexact when rounded differs from exact result
// - subnormal operands trap incomplete when flushing off
// - multiply traps only nonzero product, exponent window
// - trap type field 16..14 encodes the cause
// - interval mode forces flushing off
`timescale 1ns/100ps
`default_nettype none
`include "fpexc_consts.svh"

module fpexc_unit (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // completing operate instruction
   input wire logic opDone,
   input wire fpexc_pkg::fpexc_op_t opClass,
   input wire logic opDouble,
   input wire logic opQuad,
   input wire logic opUnimplemented,
   // operand facts
   input wire logic anySubnormal,
   input wire logic improperOperand,
   input wire logic dividendZero,
   input wire logic dividendFinite,
   input wire logic divisorZero,
   input wire logic productZero,
   input wire logic signed [`FPEXC_ER_W-1:0] resultExp,
   // result facts
   input wire logic roundedOverMax,
   input wire logic unroundedZero,
   input wire logic tinyBeforeRound,
   input wire logic accuracyLost,
   input wire logic roundedDiffers,
   // mode from the graphics status
   input wire logic intervalMode,
   // status load and store
   input wire logic loadWord,
   input wire logic loadDouble,
   input wire logic [`FPEXC_SR_W-1:0] loadData,
   input wire logic storeDone,
   // status and trap outputs
   output logic [`FPEXC_SR_W-1:0] statusReg,
   output logic stdTrap,
   output logic miscTrap,
   output logic resultCommit
);
   fpexc_if link ();

   logic [`FPEXC_SR_W-1:0] status_reg;
   logic [`FPEXC_SR_W-1:0] status_next;
   logic stdTrap_reg;
   logic stdTrap_next;
   logic miscTrap_reg;
   logic miscTrap_next;
   logic commit_reg;
   logic commit_next;

   wire fpexc_pkg::fpexc_grp_t trapMask;
   wire fpexc_pkg::fpexc_grp_t curFlags;
   wire fpexc_pkg::fpexc_grp_t accFlags;
   wire fpexc_pkg::fpexc_grp_t detected;
   wire fpexc_pkg::fpexc_grp_t trapHits;
   wire fpexc_pkg::fpexc_grp_t trapCexc;
   wire fpexc_pkg::fpexc_grp_t newCexc;
   wire fpexc_pkg::fpexc_grp_t newAexc;
   wire fpexc_pkg::fpexc_ftt_t newFtt;
   wire logic flushBit;
   wire logic flushEffective;
   wire logic unsupported;
   wire logic incomplete;
   wire logic stdTake;
   wire logic miscTake;
   wire logic isDiv;
   wire logic excInvalid;
   wire logic excOverflow;
   wire logic excUnderflow;
   wire logic excDivZero;
   wire logic excInexact;
   wire logic [`FPEXC_SR_W-1:0] loadMask;
   wire logic [`FPEXC_SR_W-1:0] loadMerged;
   wire logic [`FPEXC_SR_W-1:0] opMerged;

   // keeps the highest-priority bit so a taken trap reports one cause
   function automatic fpexc_pkg::fpexc_grp_t pickOne(
      input fpexc_pkg::fpexc_grp_t hits);
      fpexc_pkg::fpexc_grp_t sel;
      sel = `FPEXC_GRP_ZERO;
      if (hits[`FPEXC_NV]) begin
         sel[`FPEXC_NV] = 1'b1;
      end else if (hits[`FPEXC_OF]) begin
         sel[`FPEXC_OF] = 1'b1;
      end else if (hits[`FPEXC_UF]) begin
         sel[`FPEXC_UF] = 1'b1;
      end else if (hits[`FPEXC_DZ]) begin
         sel[`FPEXC_DZ] = 1'b1;
      end else if (hits[`FPEXC_NX]) begin
         sel[`FPEXC_NX] = 1'b1;
      end
      return sel;
   endfunction : pickOne

   // status field views
   assign trapMask = status_reg[`FPEXC_TEM_HI:`FPEXC_TEM_LO];
   assign curFlags = status_reg[`FPEXC_CEXC_HI:`FPEXC_CEXC_LO];
   assign accFlags = status_reg[`FPEXC_AEXC_HI:`FPEXC_AEXC_LO];
   assign flushBit = status_reg[`FPEXC_NS_BIT];

   // interval mode overrides the flush setting
   assign flushEffective = flushBit && !intervalMode;

   // incomplete-operation checker
   assign link.opClass = opClass;
   assign link.isDouble = opDouble;
   assign link.anySubnormal = anySubnormal;
   assign link.productZero = productZero;
   assign link.resultExp = resultExp;
   assign link.flushEffective = flushEffective;
   assign incomplete = link.incomplete;

   fpexc_incomplete u_incomplete (
      .chk(link.check)
   );

   // exception detection
   assign isDiv = opClass == fpexc_pkg::FPEXC_OP_DIV;
   assign excInvalid = improperOperand ||
      (isDiv && dividendZero && divisorZero);
   // 0/0 lands in invalid above, never here
   assign excDivZero = isDiv && divisorZero && dividendFinite &&
      !dividendZero;
   assign excOverflow = roundedOverMax;
   // tininess is judged on the unrounded value; loss only matters unmasked
   assign excUnderflow = !unroundedZero && tinyBeforeRound &&
      (trapMask[`FPEXC_UF] || accuracyLost);
   // overflow and masked-off underflow always carry inexact with them
   assign excInexact = roundedDiffers || excOverflow ||
      (excUnderflow && !trapMask[`FPEXC_UF]);

   assign detected[`FPEXC_NV] = excInvalid;
   assign detected[`FPEXC_OF] = excOverflow;
   assign detected[`FPEXC_UF] = excUnderflow;
   assign detected[`FPEXC_DZ] = excDivZero;
   assign detected[`FPEXC_NX] = excInexact;

   // trap decision
   assign unsupported = opUnimplemented || opQuad;
   assign miscTake = unsupported || incomplete;
   assign trapHits = trapMask & detected;
   assign stdTake = !miscTake && (trapHits != `FPEXC_GRP_ZERO);
   // overflow under an enabled mask wins over inexact, and inexact alone
   // is reported when only its mask is set
   assign trapCexc = pickOne(trapHits);

   // new fields after a completing operation
   assign newCexc = miscTake ? curFlags :
      (stdTake ? trapCexc : detected);
   assign newAexc = (miscTake || stdTake) ? accFlags :
      (accFlags | detected);
   assign newFtt = unsupported ? `FPEXC_FTT_UNSUPPORTED :
      incomplete ? `FPEXC_FTT_INCOMPLETE :
      stdTake ? `FPEXC_FTT_STD : `FPEXC_FTT_NONE;

   assign opMerged = {
      status_reg[`FPEXC_SR_W-1:`FPEXC_FTT_HI+1],
      newFtt,
      status_reg[`FPEXC_FTT_LO-1:`FPEXC_AEXC_HI+1],
      newAexc,
      newCexc
   };

   // loads leave trap type, version and reserved bits alone
   assign loadMask = loadDouble ? `FPEXC_SR_WR_MASK :
      (`FPEXC_SR_WR_MASK & `FPEXC_SR_LOW_MASK);
   assign loadMerged = (status_reg & ~loadMask) |
      (loadData & loadMask);

   always_comb begin
      status_next = status_reg;
      stdTrap_next = 1'b0;
      miscTrap_next = 1'b0;
      commit_next = 1'b0;
      if (opDone) begin
         status_next = opMerged;
         stdTrap_next = stdTake;
         miscTrap_next = miscTake;
         // a trapping operation may not write results or fcc fields
         commit_next = !(stdTake || miscTake);
      end else if (loadWord || loadDouble) begin
         status_next = loadMerged;
      end else if (storeDone) begin
         // a completed status store clears the trap type
         status_next[`FPEXC_FTT_HI:`FPEXC_FTT_LO] = `FPEXC_FTT_NONE;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         status_reg <= `FPEXC_SR_RESET;
         stdTrap_reg <= 1'b0;
         miscTrap_reg <= 1'b0;
         commit_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         stdTrap_reg <= stdTrap_next;
         miscTrap_reg <= miscTrap_next;
         commit_reg <= commit_next;
      end
   end

   // outputs
   assign statusReg = status_reg;
   assign stdTrap = stdTrap_reg;
   assign miscTrap = miscTrap_reg;
   assign resultCommit = commit_reg;
endmodule : fpexc_unit

`default_nettype wire

// ===== testbench/fpexc_unit_assertions.sv
/* fpexc_unit_assertions.sv: port-level checks of the exception unit.
 assumes: bound to fpexc_unit; one clock, async active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module fpexc_unit_assertions (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // requests
   input wire logic opDone,
   input wire logic opQuad,
   input wire logic opUnimplemented,
   input wire logic loadWord,
   input wire logic loadDouble,
   input wire logic storeDone,
   input wire logic [63:0] loadData,
   // results
   input wire logic [63:0] statusReg,
   input wire logic stdTrap,
   input wire logic miscTrap,
   input wire logic resultCommit
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_one_outcome: assert property (
      opDone |=> $onehot({stdTrap, miscTrap, resultCommit}))
      else $error("op without a single outcome");
   a_idle_quiet: assert property (
      !opDone |=> !stdTrap && !miscTrap && !resultCommit)
      else $error("outcome pulse without op");
   a_quad_unsup: assert property (
      opDone && (opQuad || opUnimplemented) |=>
      miscTrap && statusReg[16:14] == 3'h3)
      else $error("quad or unimplemented not unsupported");
   a_misc_keeps: assert property (
      opDone && (opQuad || opUnimplemented) |=>
      statusReg[9:0] == $past(statusReg[9:0]))
      else $error("misc trap changed flags");
   a_std_onebit: assert property (
      stdTrap |-> $onehot(statusReg[4:0]) && statusReg[16:14] == 3'h1)
      else $error("standard trap flags wrong");
   a_std_masked: assert property (
      stdTrap |-> (statusReg[4:0] & statusReg[27:23]) != 5'h00)
      else $error("standard trap on disabled exception");
   a_trap_aexc: assert property (
      stdTrap || miscTrap |-> $stable(statusReg[9:5]))
      else $error("accrued flags changed on trap");
   a_commit_or: assert property (
      resultCommit |-> statusReg[16:14] == 3'h0 && statusReg[9:5] ==
      ($past(statusReg[9:5]) | statusReg[4:0]))
      else $error("accrued flags not merged");
   a_store_clr: assert property (
      storeDone && !opDone && !loadWord && !loadDouble |=>
      statusReg[16:14] == 3'h0)
      else $error("store did not clear trap type");
   a_load_ro: assert property (
      (loadDouble || loadWord) && !opDone |=> statusReg[19:17] == 3'h0
      && statusReg[16:14] == $past(statusReg[16:14])
      && statusReg[9:5] == $past(loadData[9:5]))
      else $error("load touched read-only field");
   c_std: cover property (stdTrap);
   c_misc: cover property (miscTrap);
   c_commit: cover property (resultCommit && statusReg[4:0] != 5'h00);
endmodule : fpexc_unit_assertions
`default_nettype wire

// ===== testbench/fpexc_unit_test.sv
/* fpexc_unit_test.sv: self-checking bench with a reference model.
 assumes: fpexc_pkg and fpexc_consts.svh are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "fpexc_consts.svh"
module fpexc_unit_test;
   logic mclk = 1'b0, reset = 1'b1, opDone = 1'b0, opDouble = 1'b0;
   logic opQuad = 1'b0, opUnimplemented = 1'b0, anySubnormal = 1'b0;
   logic improperOperand = 1'b0, dividendZero = 1'b0;
   logic dividendFinite = 1'b0, divisorZero = 1'b0, productZero = 1'b0;
   logic roundedOverMax = 1'b0, unroundedZero = 1'b0;
   logic tinyBeforeRound = 1'b0, accuracyLost = 1'b0;
   logic roundedDiffers = 1'b0, intervalMode = 1'b0, loadWord = 1'b0;
   logic loadDouble = 1'b0, storeDone = 1'b0;
   logic [63:0] loadData = 64'h0, statusReg, mSr, msk;
   logic signed [12:0] resultExp = 13'sh0000;
   fpexc_pkg::fpexc_op_t opClass = fpexc_pkg::FPEXC_OP_OTHER;
   logic stdTrap, miscTrap, resultCommit, uf, w, inc;
   logic [2:0] eTr;
   logic [4:0] raw, hit, one;
   logic [31:0] seed = 32'h2e67;
   logic [31:0] rnd;
   int errTotal = 0, checksDone = 0, e;

   fpexc_unit fpexc_unit_i (.mclk(mclk), .reset(reset), .opDone(opDone),
      .opClass(opClass), .opDouble(opDouble), .opQuad(opQuad),
      .opUnimplemented(opUnimplemented), .anySubnormal(anySubnormal),
      .improperOperand(improperOperand), .dividendZero(dividendZero),
      .dividendFinite(dividendFinite), .divisorZero(divisorZero),
      .productZero(productZero), .resultExp(resultExp),
      .roundedOverMax(roundedOverMax), .unroundedZero(unroundedZero),
      .tinyBeforeRound(tinyBeforeRound), .accuracyLost(accuracyLost),
      .roundedDiffers(roundedDiffers), .intervalMode(intervalMode),
      .loadWord(loadWord), .loadDouble(loadDouble), .loadData(loadData),
      .storeDone(storeDone), .statusReg(statusReg), .stdTrap(stdTrap),
      .miscTrap(miscTrap), .resultCommit(resultCommit));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input string n, input logic [63:0] x, y);
      checksDone++;
      if (y !== x) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, y);
      end
   endtask : chk

   task printVerdict;
      $display("checks %0d mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : printVerdict

   // k: 0 idle, 1 op, 2 word load, 3 double load, 4 store
   task automatic drv(input int k, input logic [31:0] r, input logic [63:0] d);
      @(posedge mclk);
      opDone <= k == 1;
      loadWord <= k == 2;
      loadDouble <= k == 3;
      storeDone <= k == 4;
      loadData <= d;
      opClass <= fpexc_pkg::fpexc_op_t'(7'h01 << (r[2:0] % 3'h7));
      opDouble <= r[3];
      opQuad <= &r[6:4];
      opUnimplemented <= &r[9:7];
      anySubnormal <= &r[11:10];
      improperOperand <= &r[13:12];
      dividendZero <= r[14];
      dividendFinite <= r[15] | r[16];
      divisorZero <= r[17] && r[2:0] == 3'h2;
      productZero <= r[18];
      resultExp <= $signed({6'h00, r[25:19]}) - 13'sh0040;
      roundedOverMax <= &r[27:26];
      unroundedZero <= &r[29:28];
      tinyBeforeRound <= r[30];
      accuracyLost <= r[31];
      roundedDiffers <= r[0] ^ r[5];
   endtask : drv

   // reference model, fed with what the unit samples at the same edge
   always @(posedge mclk or posedge reset) begin
      eTr = 3'h0;
      one = 5'h00;
      e = resultExp;
      uf = !unroundedZero && tinyBeforeRound && (mSr[25] || accuracyLost);
      raw = {improperOperand || (opClass == fpexc_pkg::FPEXC_OP_DIV &&
         dividendZero && divisorZero), roundedOverMax, uf, divisorZero &&
         !dividendZero && dividendFinite, roundedDiffers || roundedOverMax
         || (uf && !mSr[25])};
      hit = raw & mSr[27:23];
      for (int i = 0; i < 5; i++) if (hit[i]) one = 5'h01 << i;
      w = e > (opDouble ? -54 : -25) && e <= 1;
      inc = (!mSr[22] || intervalMode) &&
         (opClass == fpexc_pkg::FPEXC_OP_MUL ? !productZero &&
         (anySubnormal || w) : opClass == fpexc_pkg::FPEXC_OP_DIV ?
         anySubnormal || w : opClass != fpexc_pkg::FPEXC_OP_OTHER &&
         anySubnormal);
      msk = `FPEXC_SR_WR_MASK & (loadDouble ? '1 : `FPEXC_SR_LOW_MASK);
      if (reset)
         mSr = 64'h0;
      else if (!opDone) begin
         if (loadDouble || loadWord) mSr = mSr & ~msk | loadData & msk;
         else if (storeDone) mSr[16:14] = 3'h0;
      end else if (opQuad || opUnimplemented) begin
         mSr[16:14] = 3'h3;
         eTr = 3'h2;
      end else if (inc) begin
         mSr[16:14] = 3'h2;
         eTr = 3'h2;
      end else if (hit != 5'h00) begin
         mSr[16:14] = 3'h1;
         mSr[4:0] = one;
         eTr = 3'h4;
      end else begin
         mSr[16:14] = 3'h0;
         mSr[4:0] = raw;
         mSr[9:5] = mSr[9:5] | raw;
         eTr = 3'h1;
      end
   end

   always @(negedge mclk) if (!reset) begin
      chk("statusReg", mSr, statusReg);
      chk("traps", {61'h0, eTr},
         {61'h0, stdTrap, miscTrap, resultCommit});
   end

   initial forever #2 mclk = ~mclk;

   initial begin
      #200000;
      errTotal++;
      $display("watchdog expired");
      printVerdict();
   end

   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      for (int t = 0; t < 32; t++) begin
         drv(3, 32'h0, 64'(t) << 23);
         drv(1, 32'h0c00_0000, 64'h0);
         drv(1, 32'hc000_0000, 64'h0);
         drv(1, 32'h4000_0000, 64'h0);
         drv(4, 32'h0, 64'h0);
      end
      $display("mask table test done");
      for (int m = 0; m < 8; m++) begin
         intervalMode <= m[1];
         drv(3, 32'h0, 64'(m[0]) << 22);
         for (int c = 1; c < 3; c++)
            for (int x = -56; x < 4; x++)
               drv(1, 32'(c) | 32'(m[2]) << 3 | 32'(x + 64) << 19 |
                  (x == -56 ? 32'h0004_0c00 : 32'h0), 64'h0);
      end
      $display("exponent window test done");
      for (int i = 0; i < 3000; i++) begin
         rnd = xs();
         if (rnd[31:28] == 4'h0) intervalMode <= rnd[5];
         drv(rnd[27:26] == 2'h0 ? 32'(rnd[2:0]) % 5 : 1,
            xs(), {xs(), xs()});
      end
      drv(0, 32'h0, 64'h0);
      drv(0, 32'h0, 64'h0);
      $display("random test done");
      printVerdict();
   end
endmodule : fpexc_unit_test

bind fpexc_unit fpexc_unit_assertions fpexc_unit_assertions_i (
   .mclk(mclk), .reset(reset), .opDone(opDone), .opQuad(opQuad),
   .opUnimplemented(opUnimplemented), .loadWord(loadWord),
   .loadDouble(loadDouble), .storeDone(storeDone), .loadData(loadData),
   .statusReg(statusReg), .stdTrap(stdTrap), .miscTrap(miscTrap),
   .resultCommit(resultCommit));
`default_nettype wire
